// File: verilog/gtc_top.sv
// Purpose: Gated 16-bit timer/counter with APB register access
// Assumes: core_clk 100 MHz; pins asynchronous; capture_event and sleep_mode on core_clk
// Notes: All pin inputs pass two flops; async counting keeps running in sleep
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module gtc_top (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and comparator
    input wire logic external_count_clock_pin,
    input wire logic gate_pin,
    input wire logic comparator_output,
    input wire logic osc_pin_a_port_bit,
    input wire logic osc_pin_b_port_bit,
    // System status
    input wire logic sleep_mode,
    input wire logic osc_mode_ok,
    input wire logic capture_event,
    // Outputs to core and pins
    output logic core_int_req,
    output logic wake_req,
    output logic compare_event,
    output logic count_tick,
    output logic osc_enable,
    output logic osc_pin_a_direction,
    output logic osc_pin_b_direction
);
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] capcomp;
        logic [7:0] ctrl;
        logic [2:0] ien;
        logic [4:0] misc;
        logic [1:0] dir;
        logic overflow_flag;
        logic [1:0] phase;
        logic armed;
        logic pin_prev;
        logic pin_at_off;
        logic comp_held;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic int_req;
        logic wake;
        logic cmp_evt;
        logic tick;
        logic osc_en;
        logic [1:0] dir_out;
    } gtc_state_t;

    gtc_state_t st_reg;
    gtc_state_t st_next;
    logic [4:0] pins_s;
    logic ext_s;
    logic gate_s;
    logic comp_s;
    logic [1:0] port_s;
    logic access;
    logic wr;
    logic wr_low;
    logic wr_high;
    logic cnt_wr;
    logic counter_on;
    logic clock_source_select;
    logic sync_disable;
    logic alternate_clock_select;
    logic gate_enable;
    logic gate_invert;
    logic ext_rise;
    logic ext_fall;
    logic src_tick;
    logic gate_src;
    logic gate_act;
    logic run;
    logic inc;
    logic cmp_mode;
    logic sev_match;
    logic sev_clr;
    logic ovf_set;
    logic osc_run;
    logic [1:0] dir_rd;
    logic [1:0] port_rd;
    logic [31:0] rd_data;
    logic rd_err;

    gtc_pre_if pre_link ();

    gtc_sync #(.W(5)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .d({osc_pin_b_port_bit, osc_pin_a_port_bit, comparator_output, gate_pin,
            external_count_clock_pin}),
        .q(pins_s)
    );

    gtc_prescale u_pre (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .pl(pre_link.pre)
    );

    assign ext_s = pins_s[0];
    assign gate_s = pins_s[1];
    assign comp_s = pins_s[2];
    assign port_s = pins_s[4:3];

    always_comb
    begin
        counter_on = st_reg.ctrl[gtc_pkg::CTRL_ON];
        clock_source_select = st_reg.ctrl[gtc_pkg::CTRL_CS];
        sync_disable = st_reg.ctrl[gtc_pkg::CTRL_SYNC_DIS];
        gate_enable = st_reg.ctrl[gtc_pkg::CTRL_GATE_EN];
        gate_invert = st_reg.ctrl[gtc_pkg::CTRL_GATE_INV];
        alternate_clock_select = st_reg.misc[gtc_pkg::MISC_ALT_CLK];
        cmp_mode = st_reg.misc[gtc_pkg::MISC_CMP_MODE];
        // APB strobes, write taken on the completing edge
        access = psel && penable && !st_reg.pready;
        wr = ce && psel && penable && st_reg.pready && pwrite;
        wr_low = wr && paddr == gtc_pkg::ADDR_COUNT_LOW;
        wr_high = wr && paddr == gtc_pkg::ADDR_COUNT_HIGH;
        cnt_wr = wr_low || wr_high;
        // Edge detection on the synchronised pin
        ext_rise = ext_s && !st_reg.pin_prev;
        ext_fall = !ext_s && st_reg.pin_prev;
        // Count clock selection
        if (clock_source_select)
            src_tick = ext_rise && st_reg.armed;
        else if (alternate_clock_select)
            src_tick = 1'b1;
        else
            src_tick = st_reg.phase == gtc_pkg::PHASE_LAST;
        // Gate source with optional comparator sync and polarity
        gate_src = st_reg.misc[gtc_pkg::MISC_GATE_SRC] ?
            (st_reg.misc[gtc_pkg::MISC_COMP_SYNC] ? st_reg.comp_held : comp_s) : gate_s;
        gate_act = gate_invert ? gate_src : !gate_src;
        // In sleep only unsynchronised external counting runs
        run = counter_on && (!gate_enable || gate_act)
            && (!sleep_mode || (clock_source_select && sync_disable));
        pre_link.tick = ce && run && src_tick;
        pre_link.clear = cnt_wr;
        pre_link.sel = st_reg.ctrl[gtc_pkg::CTRL_PS_LSB +: 2];
        inc = pre_link.inc;
        sev_match = inc && cmp_mode && st_reg.count == st_reg.capcomp;
        sev_clr = sev_match && st_reg.misc[gtc_pkg::MISC_SEV_EN];
        ovf_set = inc && !sev_clr && !cnt_wr && st_reg.count == gtc_pkg::COUNT_MAX;
        osc_run = st_reg.ctrl[gtc_pkg::CTRL_OSC_EN] && osc_mode_ok;
        dir_rd = osc_run ? 2'h3 : st_reg.dir;
        port_rd = osc_run ? 2'h0 : port_s;
        // Read mux, unmapped addresses answer with an error
        rd_data = 32'h0;
        rd_err = 1'b0;
        unique case (paddr)
            gtc_pkg::ADDR_CTRL: rd_data[7:0] = st_reg.ctrl;
            gtc_pkg::ADDR_COUNT_LOW: rd_data[7:0] = st_reg.count[7:0];
            gtc_pkg::ADDR_COUNT_HIGH: rd_data[7:0] = st_reg.count[15:8];
            gtc_pkg::ADDR_CAPCOMP_LOW: rd_data[7:0] = st_reg.capcomp[7:0];
            gtc_pkg::ADDR_CAPCOMP_HIGH: rd_data[7:0] = st_reg.capcomp[15:8];
            gtc_pkg::ADDR_FLAG: rd_data[0] = st_reg.overflow_flag;
            gtc_pkg::ADDR_INT_EN: rd_data[2:0] = st_reg.ien;
            gtc_pkg::ADDR_MISC: rd_data[4:0] = st_reg.misc;
            gtc_pkg::ADDR_PINS: rd_data[3:0] = {port_rd, dir_rd};
            default: rd_err = 1'b1;
        endcase
    end

    always_comb
    begin
        st_next = st_reg;
        if (ce)
        begin
            st_next.pready = access;
            st_next.pslverr = access && rd_err;
            st_next.prdata = (access && !pwrite && !rd_err) ? rd_data : 32'h0;
            st_next.phase = st_reg.phase + 2'h1;
            st_next.pin_prev = ext_s;
            // Falling edge arms counting; write or low re-enable after high disable disarms
            if (cnt_wr)
                st_next.armed = 1'b0;
            else if (ext_fall)
                st_next.armed = 1'b1;
            else if (counter_on && !st_reg.osc_en && 1'b0)
                st_next.armed = st_reg.armed;
            if (wr && paddr == gtc_pkg::ADDR_CTRL)
            begin
                st_next.ctrl = pwdata[7:0];
                if (counter_on && !pwdata[gtc_pkg::CTRL_ON])
                    st_next.pin_at_off = ext_s;
                if (!counter_on && pwdata[gtc_pkg::CTRL_ON] && st_reg.pin_at_off && !ext_s
                    && !ext_fall)
                    st_next.armed = 1'b0;
            end
            if (wr && paddr == gtc_pkg::ADDR_INT_EN)
                st_next.ien = pwdata[2:0];
            if (wr && paddr == gtc_pkg::ADDR_MISC)
                st_next.misc = pwdata[4:0];
            if (wr && paddr == gtc_pkg::ADDR_PINS)
                st_next.dir = pwdata[gtc_pkg::PINS_DIR_LSB +: 2];
            // Counter: write beats special event clear beats increment
            if (wr_low)
                st_next.count[7:0] = pwdata[7:0];
            else if (wr_high)
                st_next.count[15:8] = pwdata[7:0];
            else if (sev_clr)
                st_next.count = 16'h0000;
            else if (inc)
                st_next.count = st_reg.count + 16'h0001;
            // Capture copies the counter; hardware capture beats a software write
            if (!cmp_mode && capture_event)
                st_next.capcomp = st_reg.count;
            else if (wr && paddr == gtc_pkg::ADDR_CAPCOMP_LOW)
                st_next.capcomp[7:0] = pwdata[7:0];
            else if (wr && paddr == gtc_pkg::ADDR_CAPCOMP_HIGH)
                st_next.capcomp[15:8] = pwdata[7:0];
            // Overflow flag: set wins over the software clear
            if (ovf_set)
                st_next.overflow_flag = 1'b1;
            else if (wr && paddr == gtc_pkg::ADDR_FLAG)
                st_next.overflow_flag = pwdata[0];
            if (inc && st_reg.misc[gtc_pkg::MISC_COMP_SYNC])
                st_next.comp_held = comp_s;
            st_next.tick = inc;
            st_next.cmp_evt = sev_match;
            st_next.int_req = st_reg.overflow_flag && (&st_reg.ien);
            st_next.wake = sleep_mode && counter_on && st_reg.overflow_flag
                && st_reg.ien[gtc_pkg::IEN_OVF] && st_reg.ien[gtc_pkg::IEN_PERIPH];
            st_next.osc_en = osc_run;
            st_next.dir_out = dir_rd;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.ctrl <= gtc_pkg::CTRL_RST;
            st_reg.ien <= gtc_pkg::IEN_RST;
            st_reg.misc <= gtc_pkg::MISC_RST;
            st_reg.dir <= gtc_pkg::DIR_RST;
            st_reg.dir_out <= gtc_pkg::DIR_RST;
        end
        else
            st_reg <= st_next;
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign core_int_req = st_reg.int_req;
    assign wake_req = st_reg.wake;
    assign compare_event = st_reg.cmp_evt;
    assign count_tick = st_reg.tick;
    assign osc_enable = st_reg.osc_en;
    assign osc_pin_a_direction = st_reg.dir_out[0];
    assign osc_pin_b_direction = st_reg.dir_out[1];

    sequence s_wrap;
        ce && inc && st_reg.count == 16'hFFFF && !sev_clr && !cnt_wr;
    endsequence
    property p_rollover_flag;
        @(posedge core_clk) disable iff (!rst_n)
        s_wrap |=> st_reg.count == 16'h0000 && st_reg.overflow_flag;
    endproperty
    a_rollover_flag: assert property (p_rollover_flag) else $error("rollover lost flag");
    property p_low_write;
        @(posedge core_clk) disable iff (!rst_n)
        wr_low |=> st_reg.count[7:0] == $past(pwdata[7:0]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low byte write lost");
    property p_write_wins;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_high && sev_clr) |=> st_reg.count[15:8] == $past(pwdata[7:0]);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("clear beat write");
    property p_sev_clear;
        @(posedge core_clk) disable iff (!rst_n)
        (sev_clr && !cnt_wr && !st_reg.overflow_flag && !wr) |=>
            st_reg.count == 16'h0000 && !st_reg.overflow_flag;
    endproperty
    a_sev_clear: assert property (p_sev_clear) else $error("special event clear wrong");
    property p_int_gate;
        @(posedge core_clk) disable iff (!rst_n)
        core_int_req |-> $past(st_reg.overflow_flag) && $past(&st_reg.ien);
    endproperty
    a_int_gate: assert property (p_int_gate) else $error("interrupt without enables");
    property p_gate_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (ce && counter_on && gate_enable && !gate_act && !wr) |=> $stable(st_reg.count);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("counted while gated");
    property p_unarmed;
        @(posedge core_clk) disable iff (!rst_n)
        (ce && clock_source_select && !st_reg.armed && !wr) |=> $stable(st_reg.count);
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("counted before falling edge");
    sequence s_apb_access;
        ce && psel && penable && !pready;
    endsequence
    property p_apb_answer;
        @(posedge core_clk) disable iff (!rst_n)
        s_apb_access |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
    property p_osc_pins;
        @(posedge core_clk) disable iff (!rst_n)
        (ce && osc_run) |=> osc_pin_a_direction && osc_pin_b_direction;
    endproperty
    a_osc_pins: assert property (p_osc_pins) else $error("osc pins not inputs");
endmodule // gtc_top

// File: common/gtc_pkg.sv
// Purpose: Shared constants of the gated 16-bit timer/counter
// Assumes: APB byte addresses, 32-bit data, registers in low bits
// Notes: Control byte layout matches the counter control register
package gtc_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_CAPCOMP_LOW = 8'h0C;
    localparam logic [7:0] ADDR_CAPCOMP_HIGH = 8'h10;
    localparam logic [7:0] ADDR_FLAG = 8'h14;
    localparam logic [7:0] ADDR_INT_EN = 8'h18;
    localparam logic [7:0] ADDR_MISC = 8'h1C;
    localparam logic [7:0] ADDR_PINS = 8'h20;
    // Control register fields
    localparam int CTRL_ON = 0;
    localparam int CTRL_CS = 1;
    localparam int CTRL_SYNC_DIS = 2;
    localparam int CTRL_OSC_EN = 3;
    localparam int CTRL_PS_LSB = 4;
    localparam int CTRL_GATE_EN = 6;
    localparam int CTRL_GATE_INV = 7;
    // Interrupt enable fields
    localparam int IEN_OVF = 0;
    localparam int IEN_PERIPH = 1;
    localparam int IEN_GLOBAL = 2;
    // Misc control fields
    localparam int MISC_ALT_CLK = 0;
    localparam int MISC_GATE_SRC = 1;
    localparam int MISC_COMP_SYNC = 2;
    localparam int MISC_CMP_MODE = 3;
    localparam int MISC_SEV_EN = 4;
    // Pin register fields
    localparam int PINS_DIR_LSB = 0;
    localparam int PINS_PORT_LSB = 2;
    // Reset values and counter maximum
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] IEN_RST = 3'h0;
    localparam logic [4:0] MISC_RST = 5'h00;
    localparam logic [1:0] DIR_RST = 2'h3;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    // Instruction clock is the system clock divided by four
    localparam logic [1:0] PHASE_LAST = 2'h3;
endpackage

// File: common/gtc_pre_if.sv
// Purpose: Link between counter core and its prescaler
// Assumes: Same clock on both sides
// Notes: inc is combinational from the prescaler state
`timescale 1ns/1ps
interface gtc_pre_if;
    logic tick;
    logic clear;
    logic [1:0] sel;
    logic inc;
    modport ctl (output tick, output clear, output sel, input inc);
    modport pre (input tick, input clear, input sel, output inc);
endinterface

// File: verilog/gtc_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pins
// Assumes: One flop pair per bit
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module gtc_sync #(
    parameter int W = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gtc_sync_t;
    gtc_sync_t st_reg;
    gtc_sync_t st_next;
    always_comb
    begin
        st_next = st_reg;
        if (ce)
        begin
            st_next.s1 = d;
            st_next.s2 = st_reg.s1;
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
    assign q = st_reg.s2;

    property p_two_stage;
        @(posedge core_clk) disable iff (!rst_n)
        ($past(ce) && $past(ce, 2) && $past(rst_n) && $past(rst_n, 2)) |-> q == $past(d, 2);
    endproperty
    a_two_stage: assert property (p_two_stage) else $error("sync delay wrong");
endmodule // gtc_sync

// File: verilog/gtc_prescale.sv
// Purpose: 1/2/4/8 prescaler of the count clock
// Assumes: One tick per selected count clock event
// Notes: Not visible to software; cleared by counter writes
`timescale 1ns/1ps
module gtc_prescale (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Core link
    gtc_pre_if.pre pl
);
    typedef struct packed {
        logic [2:0] cnt;
    } gtc_pre_t;
    gtc_pre_t st_reg;
    gtc_pre_t st_next;
    logic [2:0] mask;
    always_comb
    begin
        mask = 3'((4'h1 << pl.sel) - 4'h1);
        pl.inc = pl.tick && ((st_reg.cnt & mask) == mask);
        st_next = st_reg;
        if (ce)
        begin
            if (pl.clear)
                st_next.cnt = 3'h0;
            else if (pl.inc)
                st_next.cnt = 3'h0;
            else if (pl.tick)
                st_next.cnt = st_reg.cnt + 3'h1;
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    property p_clear_on_write;
        @(posedge core_clk) disable iff (!rst_n)
        (ce && pl.clear) |=> st_reg.cnt == 3'h0;
    endproperty
    a_clear_on_write: assert property (p_clear_on_write) else $error("prescale not cleared");
    property p_div8;
        @(posedge core_clk) disable iff (!rst_n)
        (ce && pl.sel == 2'h3 && pl.tick && !pl.clear) |=> st_reg.cnt == $past(st_reg.cnt) + 3'h1;
    endproperty
    a_div8: assert property (p_div8) else $error("divide by eight wrong");
endmodule // gtc_prescale

// File: testbench/gtc_pin_model.sv
// Purpose: Far-side pins: external count clock, gate, comparator, osc port pins
// Assumes: Levels set by the bench; clock bursts on request only
// Notes: Count clock idles low between bursts
`timescale 1ns/1ps
module gtc_pin_model (
    // Clock
    input wire logic core_clk,
    // Levels from bench
    input wire logic gate_lvl,
    input wire logic cmp_lvl,
    input wire logic osc_lvl,
    // Pins
    output logic external_count_clock_pin,
    output logic gate_pin,
    output logic comparator_output,
    output logic osc_pin_a_port_bit,
    output logic osc_pin_b_port_bit
);
    initial external_count_clock_pin = 1'b0;
    assign gate_pin = gate_lvl;
    assign comparator_output = cmp_lvl;
    assign osc_pin_a_port_bit = osc_lvl;
    assign osc_pin_b_port_bit = osc_lvl;
    // Long halves so the two-flop path sees every level
    task automatic pulse(input int n);
        repeat (n)
        begin
            repeat (6) @(posedge core_clk);
            external_count_clock_pin <= 1'b1;
            repeat (6) @(posedge core_clk);
            external_count_clock_pin <= 1'b0;
        end
    endtask
endmodule // gtc_pin_model

// File: testbench/test_gated_16bit_timer_counter.sv
// Purpose: Self-checking bench of the gated timer/counter
// Assumes: APB master here, pins from the partner model
// Notes: Register rows first, then timing and event cases
`timescale 1ns/1ps
module test_gated_16bit_timer_counter;
    logic core_clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, gate_lvl = 1'b1, cmp_lvl = 1'b1, osc_lvl = 1'b1, osc_mode_ok = 1'b1;
    logic ecp, gp, cop, oa, ob, core_int_req, wake_req, compare_event, count_tick;
    logic osc_enable, osc_pin_a_direction, osc_pin_b_direction;
    logic sleep_mode = 1'b0, capture_event = 1'b0;
    int err_total = 0, compares = 0, cyc = 0, g, h;
    logic [7:0] row_a [0:6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h24};
    logic [31:0] row_d [0:6] = '{32'h5A, 32'hA5, 32'h3C, 32'hC3, 32'h06, 32'h1E, 32'h77};
    logic [31:0] row_q [0:6] = '{32'h5A, 32'hA5, 32'h3C, 32'hC3, 32'h06, 32'h1E, 32'h00};
    logic row_e [0:6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    initial forever #5 core_clk = ~core_clk;
    gtc_pin_model i_gtc_pin_model (.core_clk(core_clk), .gate_lvl(gate_lvl), .cmp_lvl(cmp_lvl),
        .osc_lvl(osc_lvl), .external_count_clock_pin(ecp), .gate_pin(gp),
        .comparator_output(cop), .osc_pin_a_port_bit(oa), .osc_pin_b_port_bit(ob));
    gtc_top i_gtc_top (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_count_clock_pin(ecp), .gate_pin(gp),
        .comparator_output(cop), .osc_pin_a_port_bit(oa), .osc_pin_b_port_bit(ob),
        .sleep_mode(sleep_mode), .osc_mode_ok(osc_mode_ok), .capture_event(capture_event),
        .core_int_req(core_int_req), .wake_req(wake_req), .compare_event(compare_event),
        .count_tick(count_tick), .osc_enable(osc_enable),
        .osc_pin_a_direction(osc_pin_a_direction), .osc_pin_b_direction(osc_pin_b_direction));
    task automatic report_and_stop();
        $display("Compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready sampled at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Cycles between two successive count ticks, after pulses of the old setting
    task automatic gap(output int n);
        n = 0;
        repeat (2) @(posedge core_clk);
        while (count_tick !== 1'b1) @(posedge core_clk);
        @(posedge core_clk);
        n = 1;
        while (count_tick !== 1'b1)
        begin
            @(posedge core_clk);
            n++;
        end
    endtask
    // Count and compare pulses over len cycles, after pulses of the old setting
    task automatic ticks(input int len, output int n, output int m);
        n = 0;
        m = 0;
        repeat (2) @(posedge core_clk);
        repeat (len)
        begin
            @(posedge core_clk);
            n += (count_tick === 1'b1) ? 1 : 0;
            m += (compare_event === 1'b1) ? 1 : 0;
        end
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h00);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0F);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, row_a[i], row_d[i]);
            apb(1'b0, row_a[i], 32'h0);
            chk(rd, row_q[i]);
            chk({31'h0, er}, {31'h0, row_e[i]});
        end
        apb(1'b1, 8'h1C, 32'h01);
        for (int p = 0; p < 4; p++)
        begin
            apb(1'b1, 8'h00, 32'h01 | (p << 4));
            gap(g);
            chk(g, 1 << p);
        end
        apb(1'b1, 8'h1C, 32'h00);
        apb(1'b1, 8'h00, 32'h01);
        gap(g);
        chk(g, 4);
        apb(1'b1, 8'h1C, 32'h01);
        apb(1'b1, 8'h00, 32'h41);
        ticks(30, g, h);
        chk(g, 0);
        apb(1'b1, 8'h00, 32'hC1);
        ticks(30, g, h);
        chk(g, 30);
        cmp_lvl <= 1'b0;
        apb(1'b1, 8'h1C, 32'h03);
        apb(1'b1, 8'h00, 32'h41);
        ticks(30, g, h);
        chk(g, 30);
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h1C, 32'h01);
        apb(1'b1, 8'h04, 32'hFF);
        apb(1'b1, 8'h08, 32'hFF);
        apb(1'b1, 8'h18, 32'h01);
        apb(1'b1, 8'h00, 32'h01);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h01);
        chk(core_int_req, 1'b0);
        apb(1'b1, 8'h18, 32'h07);
        repeat (3) @(posedge core_clk);
        chk(core_int_req, 1'b1);
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h14, 32'h00);
        repeat (3) @(posedge core_clk);
        chk(core_int_req, 1'b0);
        apb(1'b1, 8'h1C, 32'h19);
        apb(1'b1, 8'h0C, 32'h03);
        apb(1'b1, 8'h10, 32'h00);
        apb(1'b1, 8'h04, 32'h00);
        apb(1'b1, 8'h08, 32'h00);
        apb(1'b1, 8'h00, 32'h01);
        ticks(40, g, h);
        chk(g, 40);
        chk(h, 10);
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd <= 32'h03, 1'b1);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h00);
        apb(1'b1, 8'h1C, 32'h00);
        apb(1'b1, 8'h04, 32'h00);
        apb(1'b1, 8'h00, 32'h03);
        i_gtc_pin_model.pulse(3);
        repeat (8) @(posedge core_clk);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h02);
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h20, 32'h00);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0C);
        apb(1'b1, 8'h00, 32'h08);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h03);
        chk({osc_enable, osc_pin_a_direction, osc_pin_b_direction}, 3'h7);
        // Asynchronous external counting wraps in sleep and wakes the core
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h04, 32'hFF);
        apb(1'b1, 8'h08, 32'hFF);
        apb(1'b1, 8'h18, 32'h03);
        sleep_mode <= 1'b1;
        apb(1'b1, 8'h00, 32'h07);
        i_gtc_pin_model.pulse(2);
        repeat (8) @(posedge core_clk);
        chk(wake_req, 1'b1);
        chk(core_int_req, 1'b0);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h00);
        sleep_mode <= 1'b0;
        // Capture copies the stopped counter
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h04, 32'h12);
        capture_event <= 1'b1;
        @(posedge core_clk);
        capture_event <= 1'b0;
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h12);
        // Reset in mid-run
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h00);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0F);
        chk(wake_req, 1'b0);
        report_and_stop();
    end
endmodule // test_gated_16bit_timer_counter
